//--- verilog/ait_top.sv
// Audio management interrupt status and legacy I/O trap block, top level.
//
// Overview of operation
// - Mirror copy reads status without clearing.
// - Enabled bus master page end sets bits.
// - Gated codec serial or GPIO interrupt sets bit1.
// - Bit0 summarizes traps held at offset 14.
// - Even fast write data into bits 31:24.
// - Odd fast or normal write data 23:16.
// - Bit15 holds address line one.
// - Bit14 holds trapped access direction.
// - Sound/FM trap bit13 or bit10 by fast.
// - Bit12 flags enabled DMA port traps.
// - Bit11 flags enabled MIDI port traps.
// - Bits 9:0 capture trapped low address.
// - Even fast write no interrupt; odd sets 13.
// - Even fast write ports accepted without interrupt.
// - Bits 10:9 stored, returned on fast reads.
// - High DMA enable traps ports C0-DF.
// - Low DMA enable traps ports 00-0F.
// - High MIDI enable traps ports 330-331.
// - Low MIDI enable traps ports 300-301.
// - Fast read ports answered without interrupt.
// - FM enable traps ports 388-38B.
// - Causes reflected in top-level status output.
// - Reading primary status clears it.
// - Sound card enable traps selected range.
`timescale 1ns/1ps
`include "ait_params.svh"

module ait_top
  import ait_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Memory window on the audio register block.
  input wire logic mem_req,
  input wire logic mem_wr,
  input wire logic [6:0] mem_addr,
  input wire logic [3:0] mem_be,
  input wire logic [31:0] mem_wdata,
  output logic mem_ack,
  output logic [31:0] mem_rdata,
  // Host I/O cycles on the internal peripheral bus.
  input wire logic io_req,
  input wire logic io_wr,
  input wire logic [15:0] io_addr,
  input wire logic [7:0] io_wdata,
  output logic io_ack,
  output logic io_fast,
  output logic [7:0] io_rdata,
  // Audio bus master and codec sources.
  input wire logic [5:0] bm_en,
  input wire logic [5:0] bm_page_end,
  input wire logic codec_ser_irq,
  input wire logic codec_gpio_irq,
  input wire logic codec_ser_smi_en,
  input wire logic codec_gpio_smi_en,
  // Management interrupt.
  output logic smi,
  output logic pm_smi_status
);

  // ****************************************
  // Registers
  // ****************************************
  logic [15:0] en_q;
  logic [7:0] l2_q;
  logic [7:0] l2_d;
  logic [3:0] t_q;
  logic [3:0] t_d;
  logic [7:0] even_q;
  logic [7:0] odd_q;
  logic a1_q;
  logic rw_q;
  logic [9:0] taddr_q;
  logic smi_q;
  logic pm_q;
  logic mack_q;
  logic [31:0] mrd_q;
  logic iack_q;
  logic ifast_q;
  logic [7:0] ird_q;
  logic [5:0] bm_set;

  // ****************************************
  // Submodules
  // ****************************************
  ait_dec_if dif ();

  // The decoder sees the live I/O address and the current range select.
  assign dif.addr = io_addr;
  assign dif.sb_sel = en_q[`AIT_EN_SEL_HI:`AIT_EN_SEL_LO];

  ait_io_decode u_dec (
    .dif(dif)
  );

  ait_bm_collect u_bm (
    .clk_sys(clk_sys),
    .rst(rst),
    .bm_en(bm_en),
    .page_end(bm_page_end),
    .bm_set(bm_set)
  );

  // ****************************************
  // I/O cycle classification
  // ****************************************
  // A fast read or an even fast write suppresses every trap that would otherwise match it.
  wire fw_en = en_q[`AIT_EN_FW];
  wire io_fw = io_req & io_wr & fw_en & dif.cls.fw;
  wire io_fw_even = io_fw & ~io_addr[0];
  wire io_fw_odd = io_fw & io_addr[0];
  wire io_fr = io_req & ~io_wr & en_q[`AIT_EN_FR] & dif.cls.fr;
  wire sb_hit = en_q[`AIT_EN_SB] & dif.cls.sb;
  wire fm_hit = en_q[`AIT_EN_FM] & dif.cls.fm;
  wire dma_hit = (en_q[`AIT_EN_DMAH] & dif.cls.dma_hi)
    | (en_q[`AIT_EN_DMAL] & dif.cls.dma_lo);
  wire midi_hit = (en_q[`AIT_EN_MIDIH] & dif.cls.midi_hi)
    | (en_q[`AIT_EN_MIDIL] & dif.cls.midi_lo);
  wire trap_ok = io_req & ~io_fr & ~io_fw;

  // Third-level events; an odd fast write still interrupts through bit 13.
  wire ev13 = (trap_ok & (sb_hit | fm_hit) & fw_en) | io_fw_odd;
  wire ev10 = trap_ok & (sb_hit | fm_hit) & ~fw_en;
  wire ev12 = trap_ok & dma_hit;
  wire ev11 = trap_ok & midi_hit;
  wire [3:0] t_set = {ev13, ev12, ev11, ev10};
  wire trap_ev = |t_set;
  wire cap_odd = io_fw_odd | (io_req & io_wr & ~io_fw);

  // ****************************************
  // Register window decode
  // ****************************************
  wire [6:0] ofs_stat = `AIT_OFS_STAT;
  wire [6:0] ofs_mirr = `AIT_OFS_MIRR;
  wire [6:0] ofs_trap = `AIT_OFS_TRAP;
  wire [6:0] ofs_en = `AIT_OFS_EN;
  wire [15:0] en_mask = `AIT_EN_MASK;
  wire rd = mem_req & ~mem_wr;
  wire wr = mem_req & mem_wr;
  wire sel_stat = mem_addr[6:2] == ofs_stat[6:2];
  wire sel_trap = mem_addr[6:2] == ofs_trap[6:2];
  wire sel_en = mem_addr[6:2] == ofs_en[6:2];
  // Only the low lanes hold the primary copy; the mirror lanes never clear.
  wire clr_l2 = rd & sel_stat & |mem_be[1:0];
  wire rd_mirr = rd & sel_stat & (mem_be[ofs_mirr[1:0]] | mem_be[3]);
  wire clr_t = rd & sel_trap & mem_be[1];
  wire codec_ev = (codec_ser_irq & codec_ser_smi_en)
    | (codec_gpio_irq & codec_gpio_smi_en);
  wire [7:0] l2_set = {bm_set, codec_ev, trap_ev};

  // Sticky status: a new event in the clearing cycle survives the clear.
  assign l2_d = (l2_q & ~{8{clr_l2}}) | l2_set;
  assign t_d = (t_q & ~{4{clr_t}}) | t_set;

  // Read data for each mapped word; unmapped words read as zero.
  wire [31:0] rd_stat = {8'h00, l2_q, 8'h00, l2_q};
  wire [31:0] rd_trap = {even_q, odd_q, a1_q, rw_q, t_q, taddr_q};
  wire [31:0] rd_en = {16'h0000, en_q};
  wire [31:0] rd_mux = sel_stat ? rd_stat : sel_trap ? rd_trap
    : sel_en ? rd_en : 32'h0000_0000;

  // ****************************************
  // Enable register
  // ****************************************
  // Reserved bits 15:12 are dropped on write so they always read zero.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      en_q <= `AIT_EN_RST;
    end else if (wr & sel_en) begin
      en_q[7:0] <= mem_be[0] ? mem_wdata[7:0] : en_q[7:0];
      en_q[15:8] <= mem_be[1] ? (mem_wdata[15:8] & en_mask[15:8]) : en_q[15:8];
    end
  end

  // ****************************************
  // Status bits and interrupt
  // ****************************************
  // The interrupt is registered from the next state so it tracks status exactly.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      l2_q <= `AIT_L2_RST;
      t_q <= `AIT_T_RST;
      smi_q <= 1'b0;
      pm_q <= 1'b0;
    end else begin
      l2_q <= l2_d;
      t_q <= t_d;
      smi_q <= |l2_d | |t_d;
      pm_q <= |l2_d | |t_d;
    end
  end

  // ****************************************
  // Trap capture
  // ****************************************
  // Address and direction describe the last trapped cycle only.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      taddr_q <= 10'h000;
      rw_q <= 1'b0;
    end else if (trap_ev) begin
      taddr_q <= io_addr[9:0];
      rw_q <= io_wr;
    end
  end

  // Fast and normal write data bytes and address line one.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      even_q <= 8'h00;
      odd_q <= 8'h00;
      a1_q <= 1'b0;
    end else begin
      even_q <= io_fw_even ? io_wdata : even_q;
      odd_q <= cap_odd ? io_wdata : odd_q;
      a1_q <= io_fw ? io_addr[1] : a1_q;
    end
  end

  // ****************************************
  // Answers
  // ****************************************
  // Every request is answered on the next edge; no wait states exist.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mack_q <= 1'b0;
      mrd_q <= 32'h0000_0000;
      iack_q <= 1'b0;
      ifast_q <= 1'b0;
      ird_q <= 8'h00;
    end else begin
      mack_q <= mem_req;
      mrd_q <= rd ? rd_mux : 32'h0000_0000;
      iack_q <= io_req;
      ifast_q <= io_fr | io_fw;
      ird_q <= io_fr ? {6'h00, en_q[`AIT_EN_FRD_HI:`AIT_EN_FRD_LO]} : 8'h00;
    end
  end

  assign mem_ack = mack_q;
  assign mem_rdata = mrd_q;
  assign io_ack = iack_q;
  assign io_fast = ifast_q;
  assign io_rdata = ird_q;
  assign smi = smi_q;
  assign pm_smi_status = pm_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_mirror_keeps: assert property (
    (rd_mirr && !clr_l2) |=> ((l2_q & $past(l2_q)) == $past(l2_q)))
    else $error("Mirror read cleared status.");
  a_bm_status: assert property (
    (bm_set != 6'h00) |=> ((l2_q[7:2] & $past(bm_set)) == $past(bm_set)))
    else $error("Bus master status not set.");
  a_codec_status: assert property (
    ((codec_ser_irq && codec_ser_smi_en) || (codec_gpio_irq && codec_gpio_smi_en))
    |=> l2_q[`AIT_L2_CODEC])
    else $error("Codec status not set.");
  a_trap_summary: assert property (
    trap_ev |=> (l2_q[`AIT_L2_TRAP] && t_q != 4'h0))
    else $error("Trap summary missing.");
  a_even_data: assert property (
    io_fw_even |=> (even_q == $past(io_wdata) && !$past(trap_ev)))
    else $error("Even fast write mishandled.");
  a_odd_data: assert property (
    cap_odd |=> (odd_q == $past(io_wdata)))
    else $error("Odd write data not captured.");
  a_sbfm_route: assert property (
    (trap_ok && fm_hit && !fw_en) |=> t_q[0])
    else $error("FM trap not in bit 10.");
  a_odd_fast: assert property (
    io_fw_odd |=> (t_q[3] && smi_q && a1_q == $past(io_addr[1])))
    else $error("Odd fast write did not interrupt.");
  a_dma_trap: assert property (
    (io_req && en_q[`AIT_EN_DMAH] && io_addr == 16'h00c4) |=> t_q[2])
    else $error("High DMA trap missed.");
  a_fast_read: assert property (
    io_fr |=> (io_fast && io_rdata == {6'h00, $past(en_q[10:9])} && !$past(trap_ev)))
    else $error("Fast read answer wrong.");
  a_clear_l2: assert property (
    (clr_l2 && l2_set == 8'h00) |=> (l2_q == 8'h00))
    else $error("Primary read did not clear.");
  a_smi_level: assert property (
    smi == (l2_q != 8'h00 || t_q != 4'h0))
    else $error("Interrupt does not follow status.");

  c_bm_event: cover property (bm_set != 6'h00 ##1 clr_l2 ##1 !smi);
  c_trap_clear: cover property (ev11 ##[1:4] clr_t);
  c_fast_odd: cover property (io_fw_odd ##1 io_fw_even);

endmodule : ait_top

//--- verilog/ait_params.svh
// Offsets, field positions and reset values of the audio trap status block.
`ifndef AIT_PARAMS_SVH
`define AIT_PARAMS_SVH

// ****************************************
// Register byte offsets in the audio window
// ****************************************
`define AIT_OFS_STAT 7'h10
`define AIT_OFS_MIRR 7'h12
`define AIT_OFS_TRAP 7'h14
`define AIT_OFS_EN 7'h18

// ****************************************
// Enable register fields
// ****************************************
`define AIT_EN_MASK 16'h0fff
`define AIT_EN_RST 16'h0000
`define AIT_EN_FW 11
`define AIT_EN_FRD_HI 10
`define AIT_EN_FRD_LO 9
`define AIT_EN_DMAH 8
`define AIT_EN_DMAL 7
`define AIT_EN_MIDIH 6
`define AIT_EN_MIDIL 5
`define AIT_EN_FR 4
`define AIT_EN_FM 3
`define AIT_EN_SB 2
`define AIT_EN_SEL_HI 1
`define AIT_EN_SEL_LO 0

// ****************************************
// Status fields and reset values
// ****************************************
`define AIT_L2_RST 8'h00
`define AIT_T_RST 4'h0
`define AIT_L2_TRAP 0
`define AIT_L2_CODEC 1
`define AIT_L2_BM_LO 2
`define AIT_L2_BM_HI 7

// ****************************************
// Legacy I/O port ranges
// ****************************************
`define AIT_IO_SB0 12'h022
`define AIT_IO_SB1 12'h024
`define AIT_IO_FM 14'h00e2
`define AIT_IO_DMAL 12'h000
`define AIT_IO_DMAH 11'h006
`define AIT_IO_MIDIL 15'h0180
`define AIT_IO_MIDIH 15'h0198

`endif

//--- verilog/ait_pkg.sv
// Types shared by the audio trap status block.
package ait_pkg;

  typedef logic [15:0] ait_ioaddr_t;

  // Address classes found by the I/O decoder.
  typedef struct packed {
    logic sb;
    logic fm;
    logic dma_lo;
    logic dma_hi;
    logic midi_lo;
    logic midi_hi;
    logic fw;
    logic fr;
  } ait_cls_t;

endpackage : ait_pkg

//--- verilog/ait_dec_if.sv
// Interface between the top level and the I/O address decoder.
`timescale 1ns/1ps

interface ait_dec_if;
  import ait_pkg::*;
  ait_ioaddr_t addr;
  logic [1:0] sb_sel;
  ait_cls_t cls;
  modport dec (input addr, input sb_sel, output cls);
  modport use_side (output addr, output sb_sel, input cls);
endinterface : ait_dec_if

//--- verilog/ait_io_decode.sv
// Legacy sound, FM, MIDI and DMA port range decoder.
`timescale 1ns/1ps
`include "ait_params.svh"

module ait_io_decode
  import ait_pkg::*;
(
  // Address in, classes out.
  ait_dec_if.dec dif
);

  // ****************************************
  // Range compares
  // ****************************************
  // Select codes 10 and 11 name no range, so the sound card window is then closed.
  wire sb_valid = ~dif.sb_sel[1];
  wire [11:0] sb_base = dif.sb_sel[0] ? `AIT_IO_SB1 : `AIT_IO_SB0;
  wire [3:0] nib = dif.addr[3:0];
  // The x digit of the sound card offsets follows the selected base.
  wire in_sb = sb_valid & (dif.addr[15:4] == sb_base);
  wire in_fm = dif.addr[15:2] == `AIT_IO_FM;

  // Fast paths cover a few sound card ports, three FM ports for writes and all four FM ports for reads.
  wire fw_sb = in_sb & ((nib == 4'h0) | (nib == 4'h2) | (nib == 4'h8));
  wire fw_fm = in_fm & (dif.addr[1:0] != 2'h1);
  wire fr_sb = in_sb & ((nib[3:2] == 2'h0) | (nib[3:1] == 3'h4));

  // Class outputs.
  assign dif.cls.sb = in_sb;
  assign dif.cls.fm = in_fm;
  assign dif.cls.dma_lo = dif.addr[15:4] == `AIT_IO_DMAL;
  assign dif.cls.dma_hi = dif.addr[15:5] == `AIT_IO_DMAH;
  assign dif.cls.midi_lo = dif.addr[15:1] == `AIT_IO_MIDIL;
  assign dif.cls.midi_hi = dif.addr[15:1] == `AIT_IO_MIDIH;
  assign dif.cls.fw = fw_sb | fw_fm;
  assign dif.cls.fr = fr_sb | in_fm;

endmodule : ait_io_decode

//--- verilog/ait_bm_collect.sv
// End-of-page event detector for the six audio bus masters.
`timescale 1ns/1ps

module ait_bm_collect (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Bus master enable and page end marker levels.
  input wire logic [5:0] bm_en,
  input wire logic [5:0] page_end,
  // One-cycle set pulses.
  output logic [5:0] bm_set
);

  logic [5:0] pe_q;

  // Previous marker level, so that a marker held high counts once.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pe_q <= 6'h00;
    end else begin
      pe_q <= page_end;
    end
  end

  // Each master raises its bit only while enabled.
  for (genvar i = 0; i < 6; i++) begin : g_bm
    assign bm_set[i] = bm_en[i] & page_end[i] & ~pe_q[i];
  end

endmodule : ait_bm_collect

//--- tb/ait_host_model.sv
// Host model that issues register window cycles and peripheral I/O cycles.
`timescale 1ns/1ps

module ait_host_model (
  // Clock.
  input wire logic clk_sys,
  // Register window.
  output logic mem_req,
  output logic mem_wr,
  output logic [6:0] mem_addr,
  output logic [3:0] mem_be,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // Peripheral I/O cycles.
  output logic io_req,
  output logic io_wr,
  output logic [15:0] io_addr,
  output logic [7:0] io_wdata,
  input wire logic io_ack,
  input wire logic io_fast,
  input wire logic [7:0] io_rdata
);
  // Both request strobes are idle from time zero.
  initial begin
    {mem_req, mem_wr, mem_addr, mem_be, mem_wdata} = '0;
    {io_req, io_wr, io_addr, io_wdata} = '0;
  end

  // One-cycle request pulse, qualifiers held until the answer shows.
  // Released address, byte enables and data are inverted so a stale value cannot pass for a live one; the write flag is kept.
  task automatic mem_xfer(input logic w, input logic [6:0] a, input logic [3:0] be,
                          input logic [31:0] d, output logic [31:0] q);
    int n;
    @(negedge clk_sys);
    {mem_req, mem_wr, mem_addr, mem_be, mem_wdata} = {1'b1, w, a, be, d};
    @(negedge clk_sys);
    mem_req = 1'b0;
    n = 0;
    while (mem_ack !== 1'b1 && n < 8) begin
      @(negedge clk_sys);
      n++;
    end
    q = mem_rdata;
    {mem_addr, mem_be, mem_wdata} = ~{a, be, d};
  endtask : mem_xfer

  // Same shape for the I/O side.
  task automatic io_xfer(input logic w, input logic [15:0] a, input logic [7:0] d,
                         output logic [7:0] q, output logic f);
    int n;
    @(negedge clk_sys);
    {io_req, io_wr, io_addr, io_wdata} = {1'b1, w, a, d};
    @(negedge clk_sys);
    io_req = 1'b0;
    n = 0;
    while (io_ack !== 1'b1 && n < 8) begin
      @(negedge clk_sys);
      n++;
    end
    q = io_rdata;
    f = io_fast;
    {io_addr, io_wdata} = ~{a, d};
  endtask : io_xfer
endmodule : ait_host_model

//--- tb/ait_top_tb.sv
// Self-checking testbench of the audio trap status block.
`timescale 1ns/1ps

module ait_top_tb;
  logic clk_sys, rst, mem_req, mem_wr, mem_ack, io_req, io_wr, io_ack, io_fast, fq;
  logic smi, pm_smi_status, codec_ser_irq, codec_gpio_irq, codec_ser_smi_en, codec_gpio_smi_en;
  logic [6:0] mem_addr;
  logic [3:0] mem_be;
  logic [31:0] mem_wdata, mem_rdata, rd;
  logic [15:0] io_addr;
  logic [7:0] io_wdata, io_rdata, iq;
  logic [5:0] bm_en, bm_page_end;
  logic [15:0] t_en [10] = '{16'h0100, 16'h0080, 16'h0040, 16'h0020, 16'h0008, 16'h0004,
                             16'h0005, 16'h0804, 16'h0080, 16'h0006};
  logic [15:0] t_ad [10] = '{16'h00c5, 16'h000f, 16'h0331, 16'h0300, 16'h038b, 16'h022f,
                             16'h0240, 16'h0224, 16'h0010, 16'h0220};
  logic [3:0] t_m [10] = '{4'h4, 4'h4, 4'h2, 4'h2, 4'h1, 4'h1, 4'h1, 4'h8, 4'h0, 4'h0};
  logic [3:0] cdv [4] = '{4'b1010, 4'b0101, 4'b1100, 4'b1001};
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;

  ait_top dut_u (.clk_sys(clk_sys), .rst(rst), .mem_req(mem_req), .mem_wr(mem_wr),
    .mem_addr(mem_addr), .mem_be(mem_be), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .io_req(io_req), .io_wr(io_wr), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_ack(io_ack), .io_fast(io_fast), .io_rdata(io_rdata),
    .bm_en(bm_en), .bm_page_end(bm_page_end), .codec_ser_irq(codec_ser_irq),
    .codec_gpio_irq(codec_gpio_irq), .codec_ser_smi_en(codec_ser_smi_en),
    .codec_gpio_smi_en(codec_gpio_smi_en), .smi(smi), .pm_smi_status(pm_smi_status));

  ait_host_model host_u (.clk_sys(clk_sys), .mem_req(mem_req), .mem_wr(mem_wr),
    .mem_addr(mem_addr), .mem_be(mem_be), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .io_req(io_req), .io_wr(io_wr), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_ack(io_ack), .io_fast(io_fast), .io_rdata(io_rdata));

  // ****************************************
  // Clock, timeout and shared tasks
  // ****************************************
  // 50 MHz clock.
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // A hang counts as a mismatch; the full run needs well under 3000 cycles.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      end_sim();
    end
  end

  task automatic end_sim;
    $display("Comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic rd_reg(input logic [6:0] a, input logic [3:0] be);
    host_u.mem_xfer(1'b0, a, be, 32'h0, rd);
  endtask : rd_reg

  task automatic wr_en(input logic [15:0] v);
    host_u.mem_xfer(1'b1, 7'h18, 4'h3, {16'hffff, v}, rd);
  endtask : wr_en

  task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d);
    host_u.io_xfer(w, a, d, iq, fq);
  endtask : io

  // Mirror must not clear, primary must clear, and the interrupt follows.
  task automatic st_chk(input logic [7:0] e);
    chk({31'h0, smi}, {31'h0, |e}, "smi while pending");
    chk({31'h0, pm_smi_status}, {31'h0, |e}, "top level status");
    rd_reg(7'h12, 4'hc);
    chk(rd[31:16], {8'h0, e}, "mirror copy");
    rd_reg(7'h10, 4'h1);
    chk(rd[7:0], e, "primary copy");
    rd_reg(7'h12, 4'hc);
    chk(rd[31:16], 32'h0, "status after clear");
    chk({31'h0, smi}, 32'h0, "smi after clear");
  endtask : st_chk

  // Drives bus master enables, page end markers and codec sources {ser, gpio, ser_en, gpio_en}.
  task automatic src(input logic [5:0] en, input logic [5:0] pe, input logic [3:0] cd);
    @(negedge clk_sys);
    bm_en = en;
    {codec_ser_smi_en, codec_gpio_smi_en} = cd[1:0];
    @(negedge clk_sys);
    bm_page_end = pe;
    {codec_ser_irq, codec_gpio_irq} = cd[3:2];
    @(negedge clk_sys);
    bm_page_end = 6'h0;
    {codec_ser_irq, codec_gpio_irq} = 2'b00;
    @(negedge clk_sys);
  endtask : src

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst = 1'b1;
    {bm_en, bm_page_end, codec_ser_irq, codec_gpio_irq} = '0;
    {codec_ser_smi_en, codec_gpio_smi_en} = 2'b00;
    repeat (8) @(negedge clk_sys);
    rst = 1'b0;
    // Reset values, storage of enable bits and an unmapped word.
    st_chk(8'h00);
    rd_reg(7'h14, 4'h1);
    chk(rd, 32'h0, "trap reset value");
    rd_reg(7'h18, 4'h3);
    chk(rd[15:0], 32'h0, "enable reset value");
    wr_en(16'hffff);
    rd_reg(7'h18, 4'h3);
    chk(rd[15:0], 32'h0fff, "enable storage");
    rd_reg(7'h40, 4'hf);
    chk(rd, 32'h0, "unmapped word");
    // Fast reads answer from the stored bits and never interrupt.
    wr_en(16'h061c);
    io(1'b0, 16'h0389, 8'h00);
    chk({fq, iq}, 32'h103, "fast read FM port");
    io(1'b0, 16'h0221, 8'h00);
    chk({fq, iq}, 32'h103, "fast read card port");
    wr_en(16'h021c);
    io(1'b0, 16'h038b, 8'h00);
    chk({fq, iq}, 32'h101, "fast read low bits");
    st_chk(8'h00);
    // Trap table: each enable on its own range, two accesses outside.
    for (int i = 0; i < 10; i++) begin
      wr_en(t_en[i]);
      io(i[0], t_ad[i], 8'h30 + i[7:0]);
      rd_reg(7'h14, 4'h2);
      chk(rd[13:10], t_m[i], "trap cause");
      if (t_m[i] != 4'h0) begin
        chk(rd[14], i[0], "trap direction");
        chk(rd[9:0], t_ad[i][9:0], "trap address");
      end
      if (i[0]) begin
        chk(rd[23:16], 8'h30 + i[7:0], "normal write data");
      end
      st_chk({7'h0, |t_m[i]});
    end
    // Fast writes: even ones silent even with the traps armed, odd one sets bit 13.
    wr_en(16'h080d);
    io(1'b1, 16'h0248, 8'h11);
    chk({fq, smi}, 32'h2, "fast write card port");
    io(1'b1, 16'h038a, 8'h5a);
    chk({fq, smi}, 32'h2, "even fast write");
    rd_reg(7'h14, 4'h1);
    chk({rd[31:24], rd[15], rd[13:10]}, {8'h5a, 1'b1, 4'h0}, "even data and line");
    io(1'b1, 16'h038b, 8'ha5);
    chk({fq, smi}, 32'h3, "odd fast write");
    rd_reg(7'h14, 4'h2);
    chk({rd[31:15], rd[13:10]}, {16'h5aa5, 1'b1, 4'h8}, "odd fast write status");
    st_chk(8'h01);
    // Bus masters one at a time, then all markers with none enabled.
    for (int i = 0; i < 6; i++) begin
      src(6'h01 << i, 6'h01 << i, 4'h0);
      st_chk(8'h04 << i);
    end
    src(6'h00, 6'h3f, 4'h0);
    st_chk(8'h00);
    // Codec sources with and without their enables.
    for (int i = 0; i < 4; i++) begin
      src(6'h00, 6'h00, cdv[i]);
      st_chk({6'h0, (cdv[i][3] & cdv[i][1]) | (cdv[i][2] & cdv[i][0]), 1'b0});
    end
    // A second reset in mid-run must bring every register and the interrupt back to zero.
    src(6'h00, 6'h00, 4'b1010);
    chk({31'h0, smi}, 32'h1, "smi before reset");
    @(negedge clk_sys);
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    chk({31'h0, smi}, 32'h0, "smi after reset");
    rd_reg(7'h14, 4'h1);
    chk(rd, 32'h0, "trap after reset");
    rd_reg(7'h18, 4'h3);
    chk(rd, 32'h0, "enable after reset");
    st_chk(8'h00);
    end_sim();
  end
endmodule : ait_top_tb
